// ===== core/pos_front_map.vh
`ifndef POS_FRONT_MAP_VH
`define POS_FRONT_MAP_VH
// Position command sources.
`define SRC_PULSE 2'h0
`define SRC_STEP 2'h1
`define SRC_PROGRAM 2'h2
// Pulse train forms; bit 0 of the form selects negative logic.
`define FORM_DIR_PULSE 3'h0
`define FORM_QUAD 3'h2
`define FORM_CW_CCW 3'h4
`define FORM_NEG_BIT 0
// Setting limits.
`define SETTING_MAX 32'h40000000
`define STEP_MAX 16'h270F
// Gear range: res/10000000 <= num/den <= res/2.5, i.e. 2*res*den >= 5*num.
`define GEAR_LOW_DIV 64'h0000000000989680
`define GEAR_HIGH_MUL_RES 64'h0000000000000002
`define GEAR_HIGH_MUL_NUM 64'h0000000000000005
// Interpolation pacing: clock cycles between command counts.
`define STEP_PACE_NS 1000000
`define CLK_NS 50
`define STEP_PACE_CYC (`STEP_PACE_NS / `CLK_NS)
`define PROG_ENTRIES 16
`endif

// ===== core/program_table.v
// Sixteen-entry program table: target, speed and ramp time per entry.
module program_table (
  input wire core_clk,
  input wire wr_en,
  input wire [3:0] wr_index,
  input wire [31:0] wr_target,
  input wire [15:0] wr_speed,
  input wire [15:0] wr_ramp,
  input wire [3:0] rd_index,
  output reg [63:0] rd_data_q
);
  reg [63:0] mem [0:15];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_index] <= {wr_target, wr_speed, wr_ramp};
    end
    rd_data_q <= mem[rd_index];
  end
endmodule

// ===== core/position_command_gear_frontend.v
// Function
// - Source code 0 pulse train, 1 step move, 2 internal program.
// - Six pulse forms: dir+pulse, quadrature, CW/CCW; odd codes invert logic.
// - Quadrature counts every A and B edge, four counts per cycle.
// - Step mode moves signed -9999..9999 units at very low speed.
// - Program mode holds 16 entries, target, speed, ramp; linear interpolation.
// - Nonzero units per rev: command = resolution * count / units per rev.
// - Zero units per rev: command = numerator * count / denominator.
// - Two select inputs pick numerator one to four.
// - Units per rev, numerator and denominator are 32 bits; ranges 0 or 1 up to 1073741824.
// - With zero units per rev, fault when num/den below res/10000000 or above res/2.5.
// - Output command is in encoder minimum resolution units.
`include "pos_front_map.vh"
module position_command_gear_frontend (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] position_source_select,
  input wire [2:0] pulse_form_select,
  input wire pulse_in_a,
  input wire pulse_in_b,
  input wire signed [15:0] step_distance_setting,
  input wire step_start,
  input wire prog_start,
  input wire prog_wr_en,
  input wire [3:0] prog_wr_index,
  input wire [31:0] prog_wr_target,
  input wire [15:0] prog_wr_speed,
  input wire [15:0] prog_wr_ramp,
  input wire [31:0] units_per_revolution,
  input wire [31:0] gear_numerator_one,
  input wire [31:0] gear_numerator_two,
  input wire [31:0] gear_numerator_three,
  input wire [31:0] gear_numerator_four,
  input wire [31:0] gear_denominator,
  input wire [31:0] encoder_resolution,
  input wire ratio_select_low,
  input wire ratio_select_high,
  output reg signed [31:0] scaled_cmd_q,
  output reg scaled_valid_q,
  output reg gear_fault_q,
  output reg setting_fault_q,
  output reg move_busy_q
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_RUN = 4'b1000;
  localparam [31:0] PACE = `STEP_PACE_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge decode.
  reg [1:0] a_sync_q;
  reg [1:0] b_sync_q;
  reg a_prev_q;
  reg b_prev_q;
  wire neg = pulse_form_select[`FORM_NEG_BIT];
  wire a_lv = a_sync_q[1] ^ neg;
  wire b_lv = b_sync_q[1] ^ neg;
  wire a_rise = a_lv & ~a_prev_q;
  wire a_edge = a_lv ^ a_prev_q;
  wire b_rise = b_lv & ~b_prev_q;
  wire b_edge = b_lv ^ b_prev_q;
  reg pulse_cnt;
  reg pulse_dir;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      // Start at the idle level of the selected sense, so no false edge follows reset.
      a_sync_q <= {2{neg}};
      b_sync_q <= {2{neg}};
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_sync_q <= {a_sync_q[0], pulse_in_a};
      b_sync_q <= {b_sync_q[0], pulse_in_b};
      a_prev_q <= a_lv;
      b_prev_q <= b_lv;
    end
  end

  // The controller is trusted to drive the form that is configured.
  always @* begin
    pulse_cnt = 1'b0;
    pulse_dir = 1'b0;
    case ({pulse_form_select[2:1], 1'b0})
      `FORM_DIR_PULSE: begin
        pulse_cnt = a_rise;
        pulse_dir = b_lv;
      end
      `FORM_QUAD: begin
        pulse_cnt = a_edge | b_edge;
        pulse_dir = a_edge ? (a_lv ^ b_lv) : ~(a_lv ^ b_lv);
      end
      `FORM_CW_CCW: begin
        pulse_cnt = a_rise ^ b_rise;
        pulse_dir = b_rise;
      end
      default: begin
        pulse_cnt = 1'b0;
        pulse_dir = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step and program interpolators share one pacing counter.
  reg [3:0] state_q;
  reg [31:0] pace_q;
  reg [31:0] pace_len_q;
  reg signed [31:0] remain_q;
  reg [3:0] entry_q;
  reg prog_mode_q;
  wire [63:0] entry_data;
  wire [15:0] step_mag = step_distance_setting[15] ? -step_distance_setting :
                         step_distance_setting;
  wire step_ok = step_mag <= `STEP_MAX;
  wire pace_hit = (pace_q == 32'h0);
  wire interp_cnt = (state_q == ST_RUN) && pace_hit && (remain_q != 32'h0);
  wire interp_dir = remain_q[31];

  program_table u_table (
    .core_clk(core_clk),
    .wr_en(prog_wr_en),
    .wr_index(prog_wr_index),
    .wr_target(prog_wr_target),
    .wr_speed(prog_wr_speed),
    .wr_ramp(prog_wr_ramp),
    .rd_index(entry_q),
    .rd_data_q(entry_data)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pace_q <= 32'h0;
      pace_len_q <= PACE;
      remain_q <= 32'h0;
      entry_q <= 4'h0;
      prog_mode_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          entry_q <= 4'h0;
          if (position_source_select == `SRC_STEP && step_start && step_ok) begin
            remain_q <= {{16{step_distance_setting[15]}}, step_distance_setting};
            pace_len_q <= PACE;
            pace_q <= PACE - 32'h1;
            prog_mode_q <= 1'b0;
            state_q <= ST_RUN;
          end else if (position_source_select == `SRC_PROGRAM && prog_start) begin
            prog_mode_q <= 1'b1;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Table read data is registered, so give it one cycle to follow the index.
          state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          // Gear counts must stay two cycles apart, so shorter periods are clamped.
          remain_q <= entry_data[63:32];
          pace_len_q <= {16'h0, (entry_data[31:16] < 16'h0002) ? 16'h0002 :
                         entry_data[31:16]};
          pace_q <= 32'h0;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          // Constant pacing gives a linear profile; the ramp field is stored only.
          if (pace_hit) begin
            // Reloading one short makes the count period exactly pace_len_q cycles.
            pace_q <= pace_len_q - 32'h1;
          end else begin
            pace_q <= pace_q - 32'h1;
          end
          if (interp_cnt) begin
            remain_q <= interp_dir ? remain_q + 32'h1 : remain_q - 32'h1;
          end else if (remain_q == 32'h0) begin
            if (prog_mode_q && entry_q != 4'hF) begin
              entry_q <= entry_q + 4'h1;
              state_q <= ST_WAIT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source mux and electronic gear.
  reg in_cnt;
  reg in_dir;
  always @* begin
    in_cnt = 1'b0;
    in_dir = 1'b0;
    case (position_source_select)
      `SRC_PULSE: begin
        in_cnt = pulse_cnt;
        in_dir = pulse_dir;
      end
      `SRC_STEP, `SRC_PROGRAM: begin
        in_cnt = interp_cnt;
        in_dir = interp_dir;
      end
      default: begin
        in_cnt = 1'b0;
        in_dir = 1'b0;
      end
    endcase
  end

  reg [31:0] active_num;
  always @* begin
    case ({ratio_select_high, ratio_select_low})
      2'h0: active_num = gear_numerator_one;
      2'h1: active_num = gear_numerator_two;
      2'h2: active_num = gear_numerator_three;
      default: active_num = gear_numerator_four;
    endcase
  end

  wire use_upr = (units_per_revolution != 32'h0);
  wire [31:0] mul = use_upr ? encoder_resolution : active_num;
  wire [31:0] div = use_upr ? units_per_revolution : gear_denominator;
  wire div_zero = (div == 32'h0);

  // Each input count adds mul to the remainder; whole multiples of div become output.
  // Counts arrive at most every other cycle, so a serial quotient is not needed:
  // a ratio up to res/2.5 bounds the quotient per count to a single divide.
  reg [32:0] acc_q;
  wire [32:0] acc_sum = acc_q + {1'b0, mul};
  wire [32:0] quo_full = div_zero ? 33'h0 : acc_sum / {1'b0, div};
  wire [31:0] quo = quo_full[31:0];
  wire [32:0] first_full = div_zero ? 33'h0 : {1'b0, mul} / {1'b0, div};
  wire [31:0] first_quo = first_full[31:0];
  wire [32:0] first_rem = div_zero ? 33'h0 : {1'b0, mul} % {1'b0, div};
  wire [32:0] rem = div_zero ? 33'h0 : acc_sum % {1'b0, div};
  reg last_dir_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= 33'h0;
      last_dir_q <= 1'b0;
      scaled_cmd_q <= 32'h0;
      scaled_valid_q <= 1'b0;
    end else begin
      scaled_valid_q <= 1'b0;
      if (in_cnt) begin
        // A direction reversal restarts the fraction so it does not leak across.
        if (in_dir != last_dir_q) begin
          acc_q <= first_rem;
          scaled_cmd_q <= in_dir ? -first_quo : first_quo;
        end else begin
          acc_q <= rem;
          scaled_cmd_q <= in_dir ? -quo : quo;
        end
        last_dir_q <= in_dir;
        scaled_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range checks and status.
  wire [63:0] res64 = {32'h0, encoder_resolution};
  wire [63:0] num64 = {32'h0, active_num};
  wire [63:0] den64 = {32'h0, gear_denominator};
  wire ratio_low = (num64 * `GEAR_LOW_DIV) < (res64 * den64);
  wire ratio_high = (num64 * `GEAR_HIGH_MUL_NUM) > (res64 * den64 * `GEAR_HIGH_MUL_RES);
  wire num_bad = (active_num == 32'h0) || (active_num > `SETTING_MAX);
  wire den_bad = (gear_denominator == 32'h0) || (gear_denominator > `SETTING_MAX);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      gear_fault_q <= 1'b0;
      setting_fault_q <= 1'b0;
      move_busy_q <= 1'b0;
    end else begin
      gear_fault_q <= !use_upr && (ratio_low || ratio_high);
      setting_fault_q <= num_bad || den_bad || (units_per_revolution > `SETTING_MAX) ||
                         !step_ok;
      move_busy_q <= (state_q != ST_IDLE);
    end
  end
endmodule

// ===== tb/pulse_source.sv
module pulse_source (
  input wire core_clk,
  input wire [2:0] form,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ra = 1'b0;
  logic rb = 1'b0;
  logic [1:0] ph = 2'h0;
  // Odd forms drive every line inverted; idle level follows the logic sense.
  assign pin_a = ra ^ form[0];
  assign pin_b = rb ^ form[0];
  task automatic send(input logic neg);
    logic [1:0] np;
    @(posedge core_clk);
    if (form[2:1] == 2'h1) begin
      // One Gray step per count; B leads when moving forward.
      np = ph + (neg ? 2'h1 : 2'h3);
      ph <= np;
      ra <= np[0] ^ np[1];
      rb <= np[1];
    end else begin
      // Direction settles a full cycle before the active pulse edge.
      if (!form[2]) rb <= neg;
      @(posedge core_clk);
      if (form[2] && neg) rb <= 1'b1;
      else ra <= 1'b1;
      repeat (3) @(posedge core_clk);
      ra <= 1'b0;
      if (form[2]) rb <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ===== tb/pos_front_chk.sv
module pos_front_chk (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] position_source_select,
  input wire signed [15:0] step_distance_setting,
  input wire step_start,
  input wire [31:0] units_per_revolution,
  input wire [31:0] gear_numerator_one,
  input wire [31:0] gear_numerator_two,
  input wire [31:0] gear_numerator_three,
  input wire [31:0] gear_numerator_four,
  input wire [31:0] gear_denominator,
  input wire [31:0] encoder_resolution,
  input wire ratio_select_low,
  input wire ratio_select_high,
  input wire signed [31:0] scaled_cmd_q,
  input wire scaled_valid_q,
  input wire gear_fault_q,
  input wire setting_fault_q,
  input wire move_busy_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [31:0] sel_num = ratio_select_high ?
    (ratio_select_low ? gear_numerator_four : gear_numerator_three) :
    (ratio_select_low ? gear_numerator_two : gear_numerator_one);
  wire [63:0] num_x = {32'h0, sel_num};
  wire [63:0] rd = {32'h0, encoder_resolution} * {32'h0, gear_denominator};
  // Cross-multiplied so the 2.5 bound stays exact in integers.
  wire bad = units_per_revolution == 32'h0 &&
    (num_x * 64'h989680 < rd || num_x * 64'h5 > rd * 64'h2);
  wire step_bad = step_distance_setting > 16'sh270F || step_distance_setting < -16'sh270F;
  wire [31:0] cmd_mag = scaled_cmd_q[31] ? -scaled_cmd_q : scaled_cmd_q;
  a_valid_single: assert property (scaled_valid_q |=> !scaled_valid_q)
    else $error("valid stood longer than one cycle");
  a_cmd_hold: assert property (!scaled_valid_q |-> $stable(scaled_cmd_q))
    else $error("command moved without valid");
  a_gear_bad: assert property (bad [*4] |-> gear_fault_q)
    else $error("gear fault missing");
  a_gear_good: assert property (!bad [*4] |-> !gear_fault_q)
    else $error("gear fault without cause");
  a_step_range: assert property (step_bad [*4] |-> setting_fault_q)
    else $error("step range fault missing");
  a_step_busy: assert property (step_start && position_source_select == 2'h1 && !move_busy_q
    && !step_bad && !setting_fault_q && step_distance_setting != 16'sh0
    |-> ##[1:3] move_busy_q)
    else $error("step move did not start");
  a_gear_exact: assert property (scaled_valid_q && position_source_select == 2'h0 &&
    units_per_revolution == 32'h0 && gear_denominator == 32'h1 |-> cmd_mag == sel_num)
    else $error("gear result wrong");
  a_upr_scale: assert property (scaled_valid_q && position_source_select == 2'h0 &&
    units_per_revolution != 32'h0 && encoder_resolution % units_per_revolution == 32'h0
    |-> cmd_mag == encoder_resolution / units_per_revolution)
    else $error("units per rev result wrong");
  c_valid: cover property (scaled_valid_q);
  c_fault: cover property ($rose(gear_fault_q));
  c_busy: cover property ($rose(move_busy_q));
  c_prog: cover property ($rose(move_busy_q) && position_source_select == 2'h2);
endmodule
bind position_command_gear_frontend pos_front_chk chk_u (.core_clk, .rst_n,
  .position_source_select, .step_distance_setting, .step_start, .units_per_revolution,
  .gear_numerator_one, .gear_numerator_two, .gear_numerator_three, .gear_numerator_four,
  .gear_denominator, .encoder_resolution, .ratio_select_low, .ratio_select_high,
  .scaled_cmd_q, .scaled_valid_q, .gear_fault_q, .setting_fault_q, .move_busy_q);

// ===== tb/position_command_gear_frontend_bench.sv
module position_command_gear_frontend_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, step_start = 0, prog_start = 0;
  logic ratio_select_low = 0, ratio_select_high = 0, scaled_valid_q, gear_fault_q;
  logic setting_fault_q, move_busy_q, pulse_in_a, pulse_in_b;
  logic [1:0] position_source_select = 2'h0;
  logic [2:0] pulse_form_select = 3'h0;
  logic signed [15:0] step_distance_setting = 16'sh0001;
  logic [31:0] units_per_revolution = 32'h0, gear_denominator = 32'h1;
  logic [31:0] encoder_resolution = 32'hA, gear_numerator_one = 32'h1;
  logic [31:0] gear_numerator_two = 32'h2, gear_numerator_three = 32'h3;
  logic [31:0] gear_numerator_four = 32'h4;
  logic prog_wr_en = 0;
  logic [3:0] prog_wr_index = 4'h0;
  logic [31:0] prog_wr_target = 32'h0;
  logic [15:0] prog_wr_speed = 16'h0, prog_wr_ramp = 16'h0;
  logic signed [31:0] scaled_cmd_q, last_cmd;
  int miscompares = 0, samples_checked = 0, n_valid = 0, cycles = 0, pos_sum = 0;
  position_command_gear_frontend dut_u (.core_clk, .rst_n, .position_source_select,
    .pulse_form_select, .pulse_in_a, .pulse_in_b, .step_distance_setting, .step_start,
    .prog_start, .prog_wr_en, .prog_wr_index, .prog_wr_target,
    .prog_wr_speed, .prog_wr_ramp, .units_per_revolution,
    .gear_numerator_one, .gear_numerator_two, .gear_numerator_three, .gear_numerator_four,
    .gear_denominator, .encoder_resolution, .ratio_select_low, .ratio_select_high,
    .scaled_cmd_q, .scaled_valid_q, .gear_fault_q, .setting_fault_q, .move_busy_q);
  pulse_source src_u (.core_clk, .form(pulse_form_select), .pin_a(pulse_in_a),
    .pin_b(pulse_in_b));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Outputs are read at the edge, before that edge's updates land.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (scaled_valid_q === 1'b1) begin
      n_valid <= n_valid + 1;
      pos_sum <= pos_sum + scaled_cmd_q;
      last_cmd <= scaled_cmd_q;
    end
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_forms();
    int base;
    logic [31:0] mag;
    for (int f = 0; f < 6; f++) begin
      @(posedge core_clk);
      pulse_form_select <= f[2:0];
      ratio_select_low <= f[0];
      ratio_select_high <= f[1];
      // A change of form may flip idle levels, so let that settle first.
      cyc(10);
      base = n_valid;
      mag = f % 4 + 1;
      src_u.send(1'b1);
      check("cmd reverse", last_cmd, -mag);
      src_u.send(1'b0);
      check("cmd forward", last_cmd, mag);
      check("count per edge", 32'(n_valid - base), 32'h2);
    end
    $display("forms done");
  endtask
  task automatic test_upr();
    @(posedge core_clk);
    pulse_form_select <= 3'h0;
    units_per_revolution <= 32'h5;
    cyc(10);
    src_u.send(1'b0);
    check("units per rev cmd", last_cmd, 32'h2);
    units_per_revolution <= 32'h0;
    $display("units per rev done");
  endtask
  task automatic test_fault();
    @(posedge core_clk);
    ratio_select_low <= 1'b0;
    gear_numerator_one <= 32'h5;
    cyc(5);
    check("fault above range", gear_fault_q, 32'h1);
    gear_numerator_one <= 32'h1;
    encoder_resolution <= 32'h3B9ACA00;
    cyc(5);
    check("fault below range", gear_fault_q, 32'h1);
    encoder_resolution <= 32'hA;
    cyc(5);
    check("fault clear", gear_fault_q, 32'h0);
    units_per_revolution <= 32'h40000001;
    cyc(5);
    check("setting beyond range", setting_fault_q, 32'h1);
    units_per_revolution <= 32'h0;
    $display("fault done");
  endtask
  task automatic test_step();
    @(posedge core_clk);
    position_source_select <= 2'h1;
    step_distance_setting <= 16'sh2710;
    cyc(5);
    check("step beyond range", setting_fault_q, 32'h1);
    step_distance_setting <= 16'sh0001;
    cyc(5);
    step_start <= 1'b1;
    @(posedge core_clk);
    step_start <= 1'b0;
    cyc(3);
    check("step busy", move_busy_q, 32'h1);
    for (int i = 0; i < 25000 && move_busy_q !== 1'b0; i++) @(posedge core_clk);
    cyc(3);
    check("step result", last_cmd, 32'h1);
    $display("step done");
  endtask
  // Entry 0 moves +3, entry 1 moves -2 at half a count each; the rest stay put.
  task automatic test_prog();
    int base, sum0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      prog_wr_en <= 1'b1;
      prog_wr_index <= i[3:0];
      prog_wr_target <= (i == 0) ? 32'h3 : (i == 1) ? 32'hFFFFFFFE : 32'h0;
      prog_wr_speed <= 16'h4;
      prog_wr_ramp <= 16'h10;
    end
    @(posedge core_clk);
    prog_wr_en <= 1'b0;
    position_source_select <= 2'h2;
    gear_denominator <= 32'h2;
    cyc(3);
    base = n_valid;
    sum0 = pos_sum;
    prog_start <= 1'b1;
    @(posedge core_clk);
    prog_start <= 1'b0;
    cyc(3);
    check("program busy", move_busy_q, 32'h1);
    for (int i = 0; i < 300 && move_busy_q !== 1'b0; i++) @(posedge core_clk);
    cyc(3);
    check("program counts", 32'(n_valid - base), 32'h5);
    check("program last cmd", last_cmd, 32'hFFFFFFFF);
    check("program net cmd", 32'(pos_sum - sum0), 32'h0);
    $display("program done");
  endtask
  initial begin
    cyc(3);
    check("reset outputs", scaled_cmd_q | {28'h0, scaled_valid_q, gear_fault_q,
      setting_fault_q, move_busy_q}, 32'h0);
    rst_n <= 1'b1;
    test_forms();
    test_upr();
    test_fault();
    test_step();
    test_prog();
    stop_test();
  end
endmodule
